// *** design/bridge_internal_error_mask.sv ***
// bridge internal error report mask: decides which logged internal errors
// reach the bridge error reporting logic
// assumes internal_error_status is a same-clock level from the status
// register, and soft_rst is a same-clock pulse of a software reset
//
// Summary of operation
// - a set mask bit blocks its status bit from error reporting
// - masking never alters the status bit; errors stay recorded
// - mask bits are read-write, reset to zero, kept over soft reset
// - bits 0-2 mask ingress buffer posted, non-posted, completion time-outs
// - bits 4-6 mask egress buffer posted, non-posted, completion time-outs
// - bits 7-10 mask ingress data/control single and double bit errors
// - bits 11-14 mask egress data/control single and double bit errors
// - bit 15 masks the end-to-end data path parity error
// - bit 16 masks the unreliable link detected error
// - bits 17 and 18 mask replay buffer control single and double errors
// - bits 19-21, 23-28 and 31 stay read-write but act only when a DMA function exists
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "err_mask_map.svh"
module bridge_internal_error_mask #(
  parameter bit DMA_PRESENT = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  soft_rst,
  input  wire logic [`EM_ADDR_W-1:0] cfg_addr,
  input  wire logic [31:0]           cfg_wdata,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  output logic      [31:0]           cfg_rdata,
  input  wire logic [31:0]           internal_error_status,
  output logic      [31:0]           aer_report,
  output logic      [31:0]           aer_report_pulse,
  output logic                       timeout_report,
  output logic                       ecc_report,
  output logic                       parity_report,
  output logic                       link_report,
  output logic                       replay_report
);

  localparam int BASE_W = `EM_DMA_LSB;
  localparam int DMA_W  = 32 - `EM_DMA_LSB;

  ////////////////////////////////////////////////////////////////////////////
  // register access decode

  cfg_access_if acc ();

  cfg_decode u_decode (
    .addr  (cfg_addr),
    .wr    (cfg_wr),
    .rd    (cfg_rd),
    .wdata (cfg_wdata),
    .acc   (acc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mask register

  err_mask_pkg::word_t mask_q;
  err_mask_pkg::word_t mask_d;
  err_mask_pkg::word_t rw_bits;

  // reserved positions drop out of the writable set, so they read zero
  assign rw_bits = `EM_BASE_BITS | `EM_DMA_BITS;

  always_comb begin
    mask_d = mask_q;
    if (acc.wr && acc.sel == err_mask_pkg::SEL_MASK) begin
      mask_d = acc.wdata & rw_bits;
    end
  end

  // soft_rst deliberately absent: masks survive a software reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= `EM_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gating of the status bits

  logic [BASE_W-1:0] base_report;
  logic [BASE_W-1:0] base_hidden;
  logic [DMA_W-1:0]  dma_report;
  logic [DMA_W-1:0]  dma_hidden;
  err_mask_pkg::word_t report_all;
  err_mask_pkg::word_t hidden_all;
  err_mask_pkg::word_t base_bits;
  err_mask_pkg::word_t dma_bits;

  assign base_bits = `EM_BASE_BITS;
  assign dma_bits  = `EM_DMA_BITS;

  report_gate #(
    .W (BASE_W)
  ) u_base_gate (
    .status      (internal_error_status[BASE_W-1:0]),
    .mask        (mask_q[BASE_W-1:0]),
    .implemented (base_bits[BASE_W-1:0]),
    .enable      (1'b1),
    .report      (base_report),
    .hidden      (base_hidden)
  );

  // without a DMA function these mask bits are storage only
  report_gate #(
    .W (DMA_W)
  ) u_dma_gate (
    .status      (internal_error_status[31:`EM_DMA_LSB]),
    .mask        (mask_q[31:`EM_DMA_LSB]),
    .implemented (dma_bits[31:`EM_DMA_LSB]),
    .enable      (DMA_PRESENT),
    .report      (dma_report),
    .hidden      (dma_hidden)
  );

  assign report_all = {dma_report, base_report};
  assign hidden_all = {dma_hidden, base_hidden};

  ////////////////////////////////////////////////////////////////////////////
  // error classes seen by the reporting logic

  logic timeout_d;
  logic ecc_d;
  logic parity_d;
  logic link_d;
  logic replay_d;

  always_comb begin
    timeout_d = report_all[`EM_IN_POSTED_TO]
              | report_all[`EM_IN_NONPOSTED_TO]
              | report_all[`EM_IN_CPL_TO]
              | report_all[`EM_OUT_POSTED_TO]
              | report_all[`EM_OUT_NONPOSTED_TO]
              | report_all[`EM_OUT_CPL_TO];
    ecc_d     = report_all[`EM_IN_DATA_SBE]
              | report_all[`EM_IN_DATA_DBE]
              | report_all[`EM_IN_CTL_SBE]
              | report_all[`EM_IN_CTL_DBE]
              | report_all[`EM_OUT_DATA_SBE]
              | report_all[`EM_OUT_DATA_DBE]
              | report_all[`EM_OUT_CTL_SBE]
              | report_all[`EM_OUT_CTL_DBE];
    parity_d  = report_all[`EM_PARITY];
    link_d    = report_all[`EM_BAD_LINK];
    replay_d  = report_all[`EM_REPLAY_SBE]
              | report_all[`EM_REPLAY_DBE];
    // dma errors fold into the timeout and ecc classes
    timeout_d = timeout_d | (|dma_report[2:0]);
    ecc_d     = ecc_d | (|dma_report[DMA_W-1:4]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // report outputs; an error unmasked while still logged reports then

  err_mask_pkg::word_t report_q;
  err_mask_pkg::word_t report_d;
  err_mask_pkg::word_t pulse_q;
  err_mask_pkg::word_t pulse_d;
  logic [4:0]          class_q;
  logic [4:0]          class_d;

  always_comb begin
    report_d = report_all;
    pulse_d  = report_all & ~report_q;
    class_d  = {replay_d, link_d, parity_d, ecc_d, timeout_d};
    if (soft_rst) begin
      pulse_d = `EM_RD_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      report_q <= `EM_RD_IDLE;
      pulse_q  <= `EM_RD_IDLE;
      class_q  <= 5'h0;
    end else begin
      report_q <= report_d;
      pulse_q  <= pulse_d;
      class_q  <= class_d;
    end
  end

  assign aer_report       = report_q;
  assign aer_report_pulse = pulse_q;
  assign timeout_report   = class_q[0];
  assign ecc_report       = class_q[1];
  assign parity_report    = class_q[2];
  assign link_report      = class_q[3];
  assign replay_report    = class_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // sticky record of errors that were held back by a mask

  err_mask_pkg::word_t seen_q;
  err_mask_pkg::word_t seen_d;
  err_mask_pkg::word_t seen_clr;

  always_comb begin
    seen_clr = `EM_RD_IDLE;
    if (acc.wr && acc.sel == err_mask_pkg::SEL_SEEN) begin
      seen_clr = acc.wdata;
    end
    if (soft_rst) begin
      seen_clr = '1;
    end
    // a masked error arriving with the clear still sets: set wins
    seen_d = (seen_q & ~seen_clr) | hidden_all;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_q <= `EM_SEEN_RESET;
    end else begin
      seen_q <= seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: valid only in the cycle after the read strobe

  err_mask_pkg::word_t rdata_q;
  err_mask_pkg::word_t rdata_d;

  always_comb begin
    rdata_d = `EM_RD_IDLE;
    if (acc.rd) begin
      case (acc.sel)
        err_mask_pkg::SEL_MASK: rdata_d = mask_q & rw_bits;
        err_mask_pkg::SEL_SEEN: rdata_d = seen_q;
        err_mask_pkg::SEL_VIEW: rdata_d = report_q;
        default:                rdata_d = `EM_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= `EM_RD_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

endmodule : bridge_internal_error_mask

// *** design/cfg_access_if.sv ***
// decoded register access passed from the decoder to the core
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface cfg_access_if;
  err_mask_pkg::reg_sel_t sel;
  logic                   wr;
  logic                   rd;
  err_mask_pkg::word_t    wdata;

  modport decode (output sel, output wr, output rd, output wdata);
  modport core   (input sel, input wr, input rd, input wdata);
endinterface : cfg_access_if

// *** design/cfg_decode.sv ***
// address decode of the plain configuration port
// assumes strobes are single-cycle and never both high
`timescale 1ns/1ps
`include "err_mask_map.svh"
module cfg_decode (
  input  wire logic [`EM_ADDR_W-1:0] addr,
  input  wire logic                  wr,
  input  wire logic                  rd,
  input  wire logic [31:0]           wdata,
  cfg_access_if.decode               acc
);
  always_comb begin
    case (addr)
      `EM_MASK_OFF: acc.sel = err_mask_pkg::SEL_MASK;
      `EM_SEEN_OFF: acc.sel = err_mask_pkg::SEL_SEEN;
      `EM_VIEW_OFF: acc.sel = err_mask_pkg::SEL_VIEW;
      default:      acc.sel = err_mask_pkg::SEL_NONE;
    endcase
    acc.wr    = wr;
    acc.rd    = rd;
    acc.wdata = wdata;
  end
endmodule : cfg_decode

// *** design/err_mask_map.svh ***
// offsets, field positions and reset values of the error report mask block
// assumes byte addressing on a 12-bit configuration address
`ifndef ERR_MASK_MAP_SVH
`define ERR_MASK_MAP_SVH

`define EM_ADDR_W          12
`define EM_MASK_OFF        12'h04a0
`define EM_SEEN_OFF        12'h04a4
`define EM_VIEW_OFF        12'h04a8

`define EM_MASK_RESET      32'h0000_0000
`define EM_SEEN_RESET      32'h0000_0000
`define EM_RD_IDLE         32'h0000_0000
`define EM_BASE_BITS       32'h0007_fff7
`define EM_DMA_BITS        32'h9fb8_0000

`define EM_IN_POSTED_TO    0
`define EM_IN_NONPOSTED_TO 1
`define EM_IN_CPL_TO       2
`define EM_RSVD_BIT        3
`define EM_OUT_POSTED_TO   4
`define EM_OUT_NONPOSTED_TO 5
`define EM_OUT_CPL_TO      6
`define EM_IN_DATA_SBE     7
`define EM_IN_DATA_DBE     8
`define EM_IN_CTL_SBE      9
`define EM_IN_CTL_DBE      10
`define EM_OUT_DATA_SBE    11
`define EM_OUT_DATA_DBE    12
`define EM_OUT_CTL_SBE     13
`define EM_OUT_CTL_DBE     14
`define EM_PARITY          15
`define EM_BAD_LINK        16
`define EM_REPLAY_SBE      17
`define EM_REPLAY_DBE      18
`define EM_DMA_LSB         19

`endif

// *** design/err_mask_pkg.sv ***
// types shared by the error report mask block
// assumes err_mask_map.svh supplies the numbers
package err_mask_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_MASK,
    SEL_SEEN,
    SEL_VIEW
  } reg_sel_t;

endpackage : err_mask_pkg

// *** design/report_gate.sv ***
// gates one group of status bits by its mask bits
// assumes status and mask are same-clock levels
`timescale 1ns/1ps
module report_gate #(
  parameter int W = 19
) (
  input  wire logic [W-1:0] status,
  input  wire logic [W-1:0] mask,
  input  wire logic [W-1:0] implemented,
  input  wire logic         enable,
  output logic      [W-1:0] report,
  output logic      [W-1:0] hidden
);
  // status is only read here, never written, so masking cannot disturb it
  always_comb begin
    report = status & ~mask & implemented & {W{enable}};
    hidden = status & mask & implemented & {W{enable}};
  end
endmodule : report_gate

// *** dv/bridge_internal_error_mask_test.sv ***
// self-checking bench for the error report mask block
// assumes the design files and the checker are compiled first
`timescale 1ns/1ps
`include "err_mask_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end
module bridge_internal_error_mask_test;
  logic                  sys_clk;
  logic                  rst;
  logic                  soft_rst;
  logic [`EM_ADDR_W-1:0] cfg_addr;
  logic [31:0]           cfg_wdata;
  logic                  cfg_wr;
  logic                  cfg_rd;
  logic [31:0]           cfg_rdata;
  logic [31:0]           status;
  logic [31:0]           aer_report;
  logic [31:0]           pulse;
  logic [4:0]            cls;
  logic [31:0]           v;
  int                    fail_count;
  int                    num_checks;
  int                    i;
  ////////////////////////////////////////
  // no dma function here, so bits 19 and up must not gate anything
  bridge_internal_error_mask #(.DMA_PRESENT(1'b0)) DUT (
    .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .internal_error_status(status), .aer_report(aer_report),
    .aer_report_pulse(pulse), .timeout_report(cls[4]),
    .ecc_report(cls[3]), .parity_report(cls[2]),
    .link_report(cls[1]), .replay_report(cls[0]));
  function automatic logic [4:0] cls_of(input int b);
    case (b)
      0, 1, 2, 4, 5, 6: cls_of = 5'b10000;
      15: cls_of = 5'b00100;
      16: cls_of = 5'b00010;
      17, 18: cls_of = 5'b00001;
      default: cls_of = 5'b01000;
    endcase
  endfunction : cls_of
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask : wr
  // read data only stand in the cycle after the strobe, so grab it there
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end
  initial begin
    rst        = 1'b1;
    soft_rst   = 1'b0;
    cfg_addr   = 12'h000;
    cfg_wdata  = 32'h0000_0000;
    cfg_wr     = 1'b0;
    cfg_rd     = 1'b0;
    status     = 32'h0000_0000;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`EM_MASK_OFF, v);
    `CHK(v, `EM_MASK_RESET)
    wr(`EM_MASK_OFF, 32'hffff_ffff);
    rd(`EM_MASK_OFF, v);
    `CHK(v, 32'h9fbf_fff7)
    rd(12'h04ac, v);
    `CHK(v, 32'h0000_0000)
    $display("test registers done");
    wr(`EM_MASK_OFF, 32'h0001_2340);
    // soft reset lands with the rise of the reports: no pulse may follow
    status   <= 32'hffff_ffff;
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    #1;
    `CHK(pulse, 32'h0000_0000)
    tick(2);
    `CHK(aer_report, `EM_BASE_BITS & ~32'h0001_2340)
    rd(`EM_MASK_OFF, v);
    `CHK(v, 32'h0001_2340)
    $display("test soft reset done");
    // walk every low mask bit: report, mask, then unmask a still-set error
    for (i = 0; i < 19; i++) begin
      if (i == 3) continue;
      wr(`EM_MASK_OFF, 32'h0000_0000);
      status <= 32'h0000_0001 << i;
      tick(2);
      `CHK(aer_report, 32'h0000_0001 << i)
      `CHK(cls, cls_of(i))
      wr(`EM_MASK_OFF, 32'h0000_0001 << i);
      tick(1);
      `CHK(aer_report, 32'h0000_0000)
      wr(`EM_MASK_OFF, 32'h0000_0000);
      tick(1);
      `CHK(pulse, 32'h0000_0001 << i)
    end
    $display("test bit walk done");
    // every low bit was masked once above while its error stood
    rd(`EM_SEEN_OFF, v);
    `CHK(v, `EM_BASE_BITS)
    wr(`EM_VIEW_OFF, 32'h0000_0000);
    rd(`EM_VIEW_OFF, v);
    `CHK(v, 32'h0004_0000)
    wr(`EM_SEEN_OFF, 32'hffff_ffff);
    rd(`EM_SEEN_OFF, v);
    `CHK(v, 32'h0000_0000)
    $display("test seen and view done");
    stop_test;
  end
endmodule : bridge_internal_error_mask_test

// *** dv/err_mask_sva.sv ***
// checker for the error report mask block
// assumes it is bound onto bridge_internal_error_mask, one clock domain
`timescale 1ns/1ps
`include "err_mask_map.svh"
module err_mask_sva #(
  parameter bit DMA_PRESENT = 1'b0
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  soft_rst,
  input wire logic [`EM_ADDR_W-1:0] cfg_addr,
  input wire logic                  cfg_rd,
  input wire logic [31:0]           cfg_rdata,
  input wire logic [31:0]           internal_error_status,
  input wire logic [31:0]           aer_report,
  input wire logic [31:0]           aer_report_pulse,
  input wire logic                  timeout_report,
  input wire logic                  ecc_report,
  input wire logic                  parity_report,
  input wire logic                  link_report,
  input wire logic                  replay_report
);
  // dma bits count only when the port really has the dma function
  localparam logic [31:0] IMPL = DMA_PRESENT ?
    (`EM_BASE_BITS | `EM_DMA_BITS) : `EM_BASE_BITS;
  localparam logic [31:0] TO_BITS  = 32'h0038_0077;
  localparam logic [31:0] ECC_BITS = 32'h9f80_7f80;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_rd_idle;
    !$past(cfg_rd) |-> cfg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_rsvd_zero;
    $past(cfg_rd) && $past(cfg_addr) == `EM_MASK_OFF
      |-> (cfg_rdata & 32'h6040_0008) == 32'h0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved mask bit reads one");
  property p_unimpl;
    (aer_report & ~IMPL) == 32'h0000_0000;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("report on an unimplemented bit");
  property p_needs_status;
    (aer_report & ~$past(internal_error_status)) == 32'h0000_0000;
  endproperty
  a_needs_status: assert property (p_needs_status)
    else $error("report without logged status");
  property p_pulse;
    !$past(soft_rst)
      |-> aer_report_pulse == (aer_report & ~$past(aer_report));
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse does not follow report rise");
  property p_soft_quiet;
    $past(soft_rst) |-> aer_report_pulse == 32'h0000_0000;
  endproperty
  a_soft_quiet: assert property (p_soft_quiet)
    else $error("pulse right after soft reset");
  property p_timeout;
    timeout_report == |(aer_report & TO_BITS);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out class wrong");
  property p_ecc;
    ecc_report == |(aer_report & ECC_BITS);
  endproperty
  a_ecc: assert property (p_ecc)
    else $error("ecc class wrong");
  property p_single;
    {parity_report, link_report, replay_report}
      == {aer_report[15], aer_report[16], |aer_report[18:17]};
  endproperty
  a_single: assert property (p_single)
    else $error("parity, link or replay class wrong");
endmodule : err_mask_sva

bind bridge_internal_error_mask err_mask_sva #(
  .DMA_PRESENT(DMA_PRESENT)
) u_sva (
  .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
  .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
  .internal_error_status(internal_error_status),
  .aer_report(aer_report), .aer_report_pulse(aer_report_pulse),
  .timeout_report(timeout_report), .ecc_report(ecc_report),
  .parity_report(parity_report), .link_report(link_report),
  .replay_report(replay_report));
